/* design/bct_pkg.sv */
//
// Contract
// - Every instruction time is counted in raw clocks, no machine-cycle grouping.
// - Most instructions take as many clocks as they have program bytes.
// - An untaken conditional branch finishes one clock sooner than a taken one.
// - External-data writes can also be routed to the on-chip flash program memory.
// - No external memory bus; every external-data access targets on-chip resources.
// - Add, add-carry, subtract, inc, dec on register or accumulator: 1 byte, 1 clock.
// - Arithmetic or logical ops on a pointer-indirect operand: 1 byte, 2 clocks.
// - Accumulator arithmetic direct or immediate, inc/dec direct: 2 bytes, 2 clocks.
// - AND, OR, XOR of immediate into a direct byte: 3 bytes, 3 clocks.
// - AND, OR, XOR accumulator into direct, or direct/immediate into A: 2 bytes, 2 clocks.
// - AND, OR, XOR of a working register into the accumulator: 1 byte, 1 clock.
// - Clear, complement, four rotates and nibble swap of A: 1 byte, 1 clock.
// - Direct to direct or immediate to direct move: 3 bytes, 3 clocks.
// - Direct/immediate into register 2 bytes 2 clocks; register and A moves 1/1.
// - Moves into pointer-addressed RAM take 2 clocks; 1 byte from A, else 2.
// - Loading the data pointer with a 16-bit constant: 3 bytes, 3 clocks.
// - Both code memory reads: 1 byte, 3 clocks, address A plus pointer or PC.
// - All four external-data moves: 1 byte, 3 clocks, 8-bit or 16-bit address.
// - Push and pop of a direct byte take 2 clocks each.
// - Exchange of a direct byte with the accumulator: 2 bytes, 2 clocks.
// - The single unassigned opcode behaves exactly as no-operation.
//
package bct_pkg;

    // ========================================================================
    // Constants
    // ========================================================================
    localparam int unsigned CNT_W          = 3;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [7:0]  OP_NOP         = 8'h00;
    localparam logic [7:0]  OP_SPARE       = 8'hA5;
    localparam logic [7:0]  OP_CODE_RD_PC  = 8'h83;
    localparam logic [7:0]  OP_CODE_RD_DP  = 8'h93;
    localparam logic [7:0]  OP_XD_WR_DP    = 8'hF0;
    localparam logic [7:0]  OP_XD_RD_RI    = 8'hE2;
    localparam logic [7:0]  OP_LOAD_DP     = 8'h90;
    localparam logic [7:0]  OP_DIV         = 8'h84;
    localparam logic [7:0]  OP_JUMP_CARRY  = 8'h40;

    // ========================================================================
    // Types
    // ========================================================================
    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cyc;
        logic       cond;
        logic       jump;
        logic       code_rd;
        logic       xd_rd;
        logic       xd_wr;
    } bct_decode_t;

    typedef struct packed {
        logic        done;
        logic [7:0]  opcode;
        logic [15:0] operand;
        logic        taken;
    } bct_retire_t;

    typedef struct packed {
        logic        rd;
        logic        ram_wr;
        logic        flash_wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bct_xreq_t;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } bct_creq_t;

    localparam bct_decode_t DEC_NOP = '{len: 2'd1, cyc: 4'd1, default: 1'b0};

endpackage : bct_pkg

/* design/bct_decoder.sv */
`timescale 1ns/1ps
module bct_decoder
    import bct_pkg::*;
(
    input  wire logic [7:0]  opcode,
    output bct_decode_t      dec
);

    function automatic bct_decode_t mk(input logic [1:0] l, input logic [3:0] c);
        bct_decode_t d;
        d     = DEC_NOP;
        d.len = l;
        d.cyc = c;
        return d;
    endfunction : mk

    // ========================================================================
    // Length and clock table
    // ========================================================================
    always_comb begin
        dec = DEC_NOP;
        if (opcode[3]) begin
            dec = mk(2'd1, 4'd1);
            case (opcode[7:4])
                4'h7, 4'h8, 4'hA: dec = mk(2'd2, 4'd2);
                4'hB: begin
                    dec      = mk(2'd3, 4'd4);
                    dec.cond = 1'b1;
                end
                4'hD: begin
                    dec      = mk(2'd2, 4'd3);
                    dec.cond = 1'b1;
                end
                default: ;
            endcase
        end else begin
            case (opcode[2:0])
                3'd6, 3'd7: begin
                    dec = mk(2'd1, 4'd2);
                    case (opcode[7:4])
                        4'h7, 4'h8, 4'hA: dec = mk(2'd2, 4'd2);
                        4'hB: begin
                            dec      = mk(2'd3, 4'd5);
                            dec.cond = 1'b1;
                        end
                        default: ;
                    endcase
                end
                3'd5: begin
                    dec = mk(2'd2, 4'd2);
                    case (opcode[7:4])
                        4'h7, 4'h8: dec = mk(2'd3, 4'd3);
                        4'hA: dec = DEC_NOP;
                        4'hB, 4'hD: begin
                            dec      = mk(2'd3, 4'd4);
                            dec.cond = 1'b1;
                        end
                        default: ;
                    endcase
                end
                3'd4: begin
                    dec = mk(2'd1, 4'd1);
                    case (opcode[7:4])
                        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: dec = mk(2'd2, 4'd2);
                        4'h8: dec = mk(2'd1, 4'd8);
                        4'hA: dec = mk(2'd1, 4'd4);
                        4'hB: begin
                            dec      = mk(2'd3, 4'd4);
                            dec.cond = 1'b1;
                        end
                        default: ;
                    endcase
                end
                3'd1: begin
                    dec      = mk(2'd2, 4'd3);
                    dec.jump = 1'b1;
                end
                3'd0: begin
                    case (opcode[7:4])
                        4'h0: dec = DEC_NOP;
                        4'h1, 4'h2, 4'h3: begin
                            dec      = mk(2'd3, 4'd4);
                            dec.cond = 1'b1;
                        end
                        4'h4, 4'h5, 4'h6, 4'h7: begin
                            dec      = mk(2'd2, 4'd3);
                            dec.cond = 1'b1;
                        end
                        4'h8: begin
                            dec      = mk(2'd2, 4'd3);
                            dec.jump = 1'b1;
                        end
                        4'h9: dec = mk(2'd3, 4'd3);
                        4'hE: begin
                            dec       = mk(2'd1, 4'd3);
                            dec.xd_rd = 1'b1;
                        end
                        4'hF: begin
                            dec       = mk(2'd1, 4'd3);
                            dec.xd_wr = 1'b1;
                        end
                        default: dec = mk(2'd2, 4'd2);
                    endcase
                end
                default: begin
                    case (opcode[7:4])
                        4'h0, 4'h1: begin
                            dec      = opcode[0] ? mk(2'd1, 4'd1) : mk(2'd3, 4'd4);
                            dec.jump = ~opcode[0];
                        end
                        4'h2, 4'h3: begin
                            dec      = opcode[0] ? mk(2'd1, 4'd1) : mk(2'd1, 4'd5);
                            dec.jump = ~opcode[0];
                        end
                        4'h4, 4'h5, 4'h6: dec = opcode[0] ? mk(2'd3, 4'd3) : mk(2'd2, 4'd2);
                        4'h7: begin
                            dec      = opcode[0] ? mk(2'd1, 4'd3) : mk(2'd2, 4'd2);
                            dec.jump = opcode[0];
                        end
                        4'h8, 4'h9: begin
                            dec         = opcode[0] ? mk(2'd1, 4'd3) : mk(2'd2, 4'd2);
                            dec.code_rd = opcode[0];
                        end
                        4'hE: begin
                            dec       = mk(2'd1, 4'd3);
                            dec.xd_rd = 1'b1;
                        end
                        4'hF: begin
                            dec       = mk(2'd1, 4'd3);
                            dec.xd_wr = 1'b1;
                        end
                        default: dec = opcode[0] ? mk(2'd1, 4'd1) : mk(2'd2, 4'd2);
                    endcase
                end
            endcase
        end
    end

endmodule : bct_decoder

/* design/bct_core.sv */
`timescale 1ns/1ps
module bct_core
    import bct_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  prog_data,
    input  wire logic        branch_cond,
    input  wire logic [15:0] branch_target,
    input  wire logic [7:0]  acc,
    input  wire logic [15:0] data_pointer,
    input  wire logic [7:0]  working_ptr,
    input  wire logic        store_wen,
    output logic             prog_rd,
    output logic [15:0]      prog_addr,
    output bct_retire_t      retire,
    output bct_creq_t        creq,
    output bct_xreq_t        xreq
);

    // ========================================================================
    // Elaboration checks
    // ========================================================================
    if (CNT_W < 3) begin : g_cnt_check
        $error("Cycle counter is too narrow for the longest instruction.");
    end

    // ========================================================================
    // Decode and sequencing state
    // ========================================================================
    bct_decode_t        dec_now;
    bct_decode_t        dec_q;
    bct_decode_t        dec_cur;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   cnt_cur;
    logic               in_instr;
    logic               taken_q;
    logic [7:0]         opcode_q;
    logic [7:0]         op_cur;
    logic [15:0]        operand_q;
    logic [15:0]        next_operand;
    logic               active;
    logic               op_start;
    logic               last_byte;
    logic               taken_now;
    logic [3:0]         need;
    logic               finish;
    logic               more_bytes;
    logic               next_prog_rd;
    logic               access_cycle;

    bct_decoder u_decoder (
        .opcode (prog_data),
        .dec    (dec_now)
    );

    // ========================================================================
    // Cycle accounting
    // ========================================================================
    // The opcode cycle decodes straight from the fetched byte, so a one-clock
    // instruction finishes in the very cycle its opcode arrives.
    always_comb begin
        active    = in_instr | prog_rd;
        op_start  = prog_rd & ~in_instr;
        dec_cur   = in_instr ? dec_q : dec_now;
        cnt_cur   = in_instr ? cnt : '0;
        op_cur    = in_instr ? opcode_q : prog_data;
        last_byte = active && ({1'b0, cnt_cur} == {2'b00, dec_cur.len} - 4'd1);
        taken_now = taken_q;
        if (last_byte) begin
            taken_now = dec_cur.cond ? branch_cond : dec_cur.jump;
        end
        need = dec_cur.cyc;
        if (dec_cur.cond && !taken_now) begin
            need = dec_cur.cyc - 4'd1;
        end
        finish       = active && ({1'b0, cnt_cur} == need - 4'd1);
        more_bytes   = active && ({1'b0, cnt_cur} + 4'd1 < {2'b00, dec_cur.len});
        next_prog_rd = ~active | finish | more_bytes;
        access_cycle = active && (cnt_cur == 3'd1);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_rd <= 1'b0;
        end else begin
            prog_rd <= next_prog_rd;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            in_instr <= 1'b0;
            cnt      <= '0;
        end else begin
            in_instr <= active & ~finish;
            cnt      <= (finish || !active) ? '0 : cnt_cur + 3'd1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_q    <= DEC_NOP;
            opcode_q <= OP_NOP;
            taken_q  <= 1'b0;
        end else begin
            if (op_start) begin
                dec_q    <= dec_now;
                opcode_q <= prog_data;
            end
            if (op_start) begin
                taken_q <= 1'b0;
            end
            if (last_byte) begin
                taken_q <= taken_now;
            end
        end
    end

    // ========================================================================
    // Program counter
    // ========================================================================
    // A redirect only ever lands on a cycle with no byte fetch, since every
    // taken transfer runs at least one clock past its last byte.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_addr <= PC_RESET;
        end else if (finish && taken_now) begin
            prog_addr <= branch_target;
        end else if (prog_rd) begin
            prog_addr <= prog_addr + 16'h0001;
        end
    end

    // ========================================================================
    // Operand capture and retirement
    // ========================================================================
    always_comb begin
        next_operand = op_start ? 16'h0000 : operand_q;
        if (prog_rd && cnt_cur == 3'd1) begin
            next_operand[7:0] = prog_data;
        end
        if (prog_rd && cnt_cur == 3'd2) begin
            next_operand[15:8] = prog_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            operand_q <= 16'h0000;
        end else begin
            operand_q <= next_operand;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            retire <= '0;
        end else begin
            retire.done    <= finish;
            retire.opcode  <= op_cur;
            retire.operand <= next_operand;
            retire.taken   <= taken_now & finish;
        end
    end

    // ========================================================================
    // On-chip memory requests
    // ========================================================================
    // The PC seen in the second clock already points past the one-byte
    // instruction, which is the base the PC-relative code read needs.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            creq <= '0;
        end else begin
            creq.rd   <= access_cycle & dec_cur.code_rd;
            creq.addr <= {8'h00, acc} + (op_cur[4] ? data_pointer : prog_addr);
        end
    end

    // There is no external bus: every external-data access leaves on these
    // on-chip strobes, and a write goes to flash only while store_wen is set.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            xreq <= '0;
        end else begin
            xreq.rd       <= access_cycle & dec_cur.xd_rd;
            xreq.ram_wr   <= access_cycle & dec_cur.xd_wr & ~store_wen;
            xreq.flash_wr <= access_cycle & dec_cur.xd_wr & store_wen;
            xreq.addr     <= op_cur[1] ? {8'h00, working_ptr} : data_pointer;
            xreq.wdata    <= acc;
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    logic [3:0] gap_cnt;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_cnt <= 4'd0;
        end else if (prog_rd) begin
            gap_cnt <= 4'd0;
        end else if (gap_cnt != 4'hF) begin
            gap_cnt <= gap_cnt + 4'd1;
        end
    end

    fetch_gap_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        gap_cnt < 4'd8)
        else $error("Fetch stalled longer than the slowest instruction.");

    reg_add_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data[7:3] == 5'b00101 |-> ##1 retire.done && prog_rd)
        else $error("Register add did not retire in one clock.");

    ind_alu_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data[7:1] == 7'b0101011 |-> ##1 !retire.done && !prog_rd ##1 retire.done)
        else $error("Indirect logic op did not take two clocks.");

    imm_add_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data[7:4] == 4'h2 && prog_data[3:1] == 3'b010 |->
        ##1 prog_rd && !retire.done ##1 retire.done)
        else $error("Two-byte accumulator add did not take two clocks.");

    imm_direct_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && (prog_data == 8'h53 || prog_data == 8'h85) |->
        ##1 prog_rd [*2] ##1 retire.done)
        else $error("Three-byte direct op did not take three clocks.");

    rotate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && (prog_data == 8'h23 || prog_data == 8'hC4) |-> ##1 retire.done)
        else $error("Accumulator rotate or swap exceeded one clock.");

    load_dp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_LOAD_DP |-> ##3 retire.done && retire.opcode == OP_LOAD_DP)
        else $error("Pointer load did not retire on the third clock.");

    code_rd_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && (prog_data == OP_CODE_RD_PC || prog_data == OP_CODE_RD_DP) |->
        ##2 creq.rd ##1 retire.done && !creq.rd)
        else $error("Code read timing broken.");

    code_pc_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_CODE_RD_PC |->
        ##2 creq.addr == {8'h00, $past(acc)} + $past(prog_addr))
        else $error("PC-relative code address wrong.");

    flash_wr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_XD_WR_DP && store_wen |=> store_wen |->
        ##1 xreq.flash_wr && !xreq.ram_wr ##1 retire.done)
        else $error("Flash-enabled write not routed to flash.");

    xd_rd_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_XD_RD_RI |=>
        ##1 xreq.rd && xreq.addr[15:8] == 8'h00 ##1 retire.done)
        else $error("Pointer-register external read timing broken.");

    untaken_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_JUMP_CARRY ##1 !branch_cond |->
        ##1 retire.done && !retire.taken)
        else $error("Untaken short branch did not finish in two clocks.");

    taken_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_JUMP_CARRY ##1 branch_cond |->
        ##1 !retire.done ##1 retire.done && retire.taken)
        else $error("Taken short branch did not take three clocks.");

    spare_op_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_SPARE |-> ##1 retire.done && prog_rd && !xreq.rd)
        else $error("Spare opcode not treated as no-operation.");

    div_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        op_start && prog_data == OP_DIV |-> ##1 !prog_rd [*7] ##1 retire.done)
        else $error("Divide did not take eight clocks.");

endmodule : bct_core

/* testbench/bct_prog_mem.sv */
`timescale 1ns/1ps
module bct_prog_mem (
    input  wire logic [15:0] prog_addr,
    input  wire logic        prog_rd,
    output logic [7:0]       prog_data
);
    // ========================================================================
    // Program store
    // ========================================================================
    logic [7:0] mem [0:15];
    // Only sixteen bytes exist, so higher addresses alias onto them.
    // Unread cycles show the inverted byte, so a stray sample sees the wrong value.
    assign prog_data = prog_rd ? mem[prog_addr[3:0]] : ~mem[prog_addr[3:0]];
endmodule : bct_prog_mem

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb
    import bct_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  prog_data;
    logic        branch_cond = 1'b0;
    logic [15:0] branch_target = 16'h000C;
    logic [7:0]  acc = 8'h3C;
    logic [15:0] data_pointer = 16'h1200;
    logic [7:0]  working_ptr = 8'h47;
    logic        store_wen = 1'b0;
    logic        prog_rd;
    logic [15:0] prog_addr;
    bct_retire_t retire;
    bct_creq_t   creq;
    bct_xreq_t   xreq;
    bct_xreq_t   xs;
    bct_creq_t   cs;
    int          errors = 0;
    int          n_compared = 0;
    int          ticks = 0;

    bct_core i_bct_core (.sys_clk(sys_clk), .arst_n(arst_n), .prog_data(prog_data), .branch_cond(branch_cond),
        .branch_target(branch_target), .acc(acc), .data_pointer(data_pointer), .working_ptr(working_ptr),
        .store_wen(store_wen), .prog_rd(prog_rd), .prog_addr(prog_addr), .retire(retire), .creq(creq), .xreq(xreq));
    bct_prog_mem i_bct_prog_mem (.prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data));

    // ========================================================================
    // Clock and watchdog
    // ========================================================================
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        ticks++;
        if (ticks == 5000) begin
            errors++;
            wrap_up();
        end
    end

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Runs one instruction from address zero after a fresh reset; cycle 0 is the opcode fetch.
    task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input int len,
                       input int cyc, input logic [15:0] pc);
        int n;
        int nrd;
        @(posedge sys_clk);
        #1 arst_n = 1'b0;
        for (int i = 0; i < 16; i++) i_bct_prog_mem.mem[i] = OP_NOP;
        i_bct_prog_mem.mem[0] = op;
        i_bct_prog_mem.mem[1] = b2;
        i_bct_prog_mem.mem[2] = b3;
        @(posedge sys_clk);
        #1 arst_n = 1'b1;
        @(posedge sys_clk);
        #1 n = 0;
        nrd = 0;
        xs = '0;
        cs = '0;
        while (retire.done !== 1'b1 && n < 20) begin
            nrd += (prog_rd === 1'b1);
            @(posedge sys_clk);
            #1 n++;
            if ((xreq.rd | xreq.ram_wr | xreq.flash_wr) === 1'b1) xs = xreq;
            if (creq.rd === 1'b1) cs = creq;
        end
        chk("clocks", cyc, n);
        chk("fetched bytes", len, nrd);
        chk("opcode", op, retire.opcode);
        chk("operand", {(len > 2) ? b3 : 8'h00, (len > 1) ? b2 : 8'h00}, retire.operand);
        chk("next pc", pc, prog_addr);
    endtask : run

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic test_timing();
        run(8'h28, 8'h5A, 8'hA5, 1, 1, 16'h0001);
        run(8'h25, 8'h5A, 8'hA5, 2, 2, 16'h0002);
        run(8'h26, 8'h5A, 8'hA5, 1, 2, 16'h0001);
        run(8'h56, 8'h5A, 8'hA5, 1, 2, 16'h0001);
        run(OP_DIV, 8'h5A, 8'hA5, 1, 8, 16'h0001);
        run(8'hA4, 8'h5A, 8'hA5, 1, 4, 16'h0001);
        run(8'h53, 8'h5A, 8'hA5, 3, 3, 16'h0003);
        run(8'h42, 8'h5A, 8'hA5, 2, 2, 16'h0002);
        run(8'h58, 8'h5A, 8'hA5, 1, 1, 16'h0001);
        run(8'hC4, 8'h5A, 8'hA5, 1, 1, 16'h0001);
        run(8'h85, 8'h5A, 8'hA5, 3, 3, 16'h0003);
        run(8'h78, 8'h5A, 8'hA5, 2, 2, 16'h0002);
        run(8'hF6, 8'h5A, 8'hA5, 1, 2, 16'h0001);
        run(8'h76, 8'h5A, 8'hA5, 2, 2, 16'h0002);
        run(OP_LOAD_DP, 8'h5A, 8'hA5, 3, 3, 16'h0003);
        run(8'hC0, 8'h5A, 8'hA5, 2, 2, 16'h0002);
        run(8'hC5, 8'h5A, 8'hA5, 2, 2, 16'h0002);
        run(OP_SPARE, 8'h5A, 8'hA5, 1, 1, 16'h0001);
        $display("test_timing done");
    endtask : test_timing

    task automatic test_branch();
        branch_cond = 1'b1;
        run(OP_JUMP_CARRY, 8'h0A, 8'h00, 2, 3, 16'h000C);
        chk("taken", 1'b1, retire.taken);
        run(8'hB4, 8'h0A, 8'h05, 3, 4, 16'h000C);
        chk("long taken", 1'b1, retire.taken);
        branch_cond = 1'b0;
        run(OP_JUMP_CARRY, 8'h0A, 8'h00, 2, 2, 16'h0002);
        chk("untaken", 1'b0, retire.taken);
        run(8'hB4, 8'h0A, 8'h05, 3, 3, 16'h0003);
        chk("long untaken", 1'b0, retire.taken);
        run(8'h02, 8'h00, 8'h0C, 3, 4, 16'h000C);
        chk("long jump", 1'b1, retire.taken);
        $display("test_branch done");
    endtask : test_branch

    task automatic test_data_moves();
        run(OP_CODE_RD_DP, 8'h00, 8'h00, 1, 3, 16'h0001);
        chk("code addr dp", 16'h123C, cs.addr & {16{cs.rd}});
        run(OP_CODE_RD_PC, 8'h00, 8'h00, 1, 3, 16'h0001);
        chk("code addr pc", 16'h003D, cs.addr & {16{cs.rd}});
        store_wen = 1'b1;
        run(OP_XD_WR_DP, 8'h00, 8'h00, 1, 3, 16'h0001);
        chk("flash write", 3'b001, {xs.rd, xs.ram_wr, xs.flash_wr});
        chk("flash addr", 16'h1200, xs.addr);
        chk("flash data", 8'h3C, xs.wdata);
        store_wen = 1'b0;
        run(8'hF2, 8'h00, 8'h00, 1, 3, 16'h0001);
        chk("ram write", 3'b010, {xs.rd, xs.ram_wr, xs.flash_wr});
        chk("ram addr", 16'h0047, xs.addr);
        run(8'hE0, 8'h00, 8'h00, 1, 3, 16'h0001);
        chk("read dp", 19'h41200, {xs.rd, xs.ram_wr, xs.flash_wr, xs.addr});
        run(OP_XD_RD_RI, 8'h00, 8'h00, 1, 3, 16'h0001);
        chk("read ri", 16'h0047, xs.addr & {16{xs.rd}});
        $display("test_data_moves done");
    endtask : test_data_moves

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (10) @(posedge sys_clk);
        test_timing();
        test_branch();
        test_data_moves();
        wrap_up();
    end
endmodule : tb
